// ==== logic/stc_pkg.sv ====
// stc_pkg: register map, field positions and reset values of the
// start-pattern, transmitter and clock-output configuration bank.
// assumes a 32-bit ahb-lite bus with one register per aligned word.
package stc_pkg;
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_RX_CFG     = 6'h12;  // receive config (pattern control)
    localparam logic [5:0] IDX_PAT_FIRST  = 6'h16;  // start pattern byte sent first
    localparam logic [5:0] IDX_PAT_SECOND = 6'h17;  // start pattern byte sent second
    localparam logic [5:0] IDX_PAT_THIRD  = 6'h18;  // start pattern byte sent third
    localparam logic [5:0] IDX_PAT_LAST   = 6'h19;  // start pattern byte sent last
    localparam logic [5:0] IDX_TX_CFG     = 6'h1a;  // transmitter config
    localparam logic [5:0] IDX_OSC_CFG    = 6'h1b;  // clock output config

    // reset values
    localparam logic [7:0] RST_RX_CFG  = 8'h18;     // 4 pattern bytes, detect off
    localparam logic [7:0] RST_PAT     = 8'h00;     // pattern bytes
    localparam logic [7:0] RST_TX_CFG  = 8'h70;     // cutoff code 0111, power 000
    localparam logic [7:0] RST_OSC_CFG = 8'hbc;     // clkout on, divider 01111

    // writable bit masks; unused bits read back zero
    localparam logic [7:0] MASK_RX_CFG  = 8'h3e;    // bits 5..1
    localparam logic [7:0] MASK_TX_CFG  = 8'hfe;    // bit 0 unused
    localparam logic [7:0] MASK_OSC_CFG = 8'hfc;    // bits 1..0 unused

    // field positions
    localparam int RX_RECOG_BIT   = 5;              // pattern detection enable
    localparam int RX_SIZE_LSB    = 3;              // pattern_byte_count, 2 bits
    localparam int RX_TOL_LSB     = 1;              // bit error tolerance, 2 bits
    localparam int TX_CUTOFF_LSB  = 4;              // tx_filter_cutoff_code, 4 bits
    localparam int TX_POWER_LSB   = 1;              // output power code, 3 bits
    localparam int OSC_EN_BIT     = 7;              // clock output enable
    localparam int OSC_DIV_LSB    = 2;              // divider value m, 5 bits

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;   // single transfer
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;   // burst beat
    localparam logic [2:0] HSIZE_WORD    = 3'b010;  // 32-bit access
    localparam logic       HRESP_OKAY    = 1'b0;    // only answer given

    // pattern transmit sequencer states, gray along idle -> send
    typedef enum logic [0:0] {
        STC_IDLE = 1'b0,                            // waiting for a start request
        STC_SEND = 1'b1                             // shifting pattern bits out
    } stc_tx_state_t;
endpackage

// ==== logic/stc_clk_div.sv ====
// stc_clk_div: divides the crystal clock by 2*m for the buffered clock
// output. assumes hclk is the crystal clock; ce freezes the divider.
`timescale 1ns/100ps
module stc_clk_div #(
    parameter int DIV_W = 5                         // width of divider value m
) (
    input  wire logic             hclk,             // crystal clock
    input  wire logic             hresetn,          // async reset, active low
    input  wire logic             ce,               // clock enable
    input  wire logic [DIV_W-1:0] div_m,            // half period in crystal cycles
    output logic                  clk_div_q         // divided clock, from flop
);
    logic [DIV_W-1:0] cnt_q;                        // cycles spent in this half
    logic [DIV_W-1:0] cnt_d;                        // next count
    logic             wrap;                         // half period ends now

    if (DIV_W < 1)
    begin : g_chk
        $error("stc_clk_div: DIV_W must be at least 1");
    end

    // a half period is m cycles, so a full period is 2*m
    assign wrap  = (cnt_q >= div_m - DIV_W'(1));
    assign cnt_d = wrap ? '0 : cnt_q + DIV_W'(1);

    // count and toggle; a divider change applies to the half period already in progress
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q     <= '0;
            clk_div_q <= 1'b0;
        end
        else if (ce)
        begin
            cnt_q <= cnt_d;
            if (wrap)
                clk_div_q <= ~clk_div_q;
        end
    end
endmodule

// ==== logic/stc_regs.sv ====
// stc_regs: start pattern, transmitter and clock output configuration
// bank with ahb-lite register access, pattern sender and detector.
// assumes hclk is the crystal clock and the modem paces bits by strobes.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps

// How it works
// - send pattern bytes first register first
// - cutoff code sits in bits 7..4
// - power code bits 3..1, 000 strongest
// - clock output only when enable bit set
// - output clock is crystal over 2*m
// - divider zero passes crystal clock through
// - size field picks one to four bytes
// - detect pattern only when recognition enabled
// - accept pattern within tolerated bit errors
module stc_regs #(
    parameter int DIV_W = 5                         // clock divider field width
) (
    input  wire logic        hclk,                  // crystal derived clock
    input  wire logic        hresetn,               // async reset, active low
    input  wire logic        ce,                    // clock enable, freezes all state

    input  wire logic        hsel,                  // slave select
    input  wire logic [31:0] haddr,                 // byte address
    input  wire logic [1:0]  htrans,                // transfer type
    input  wire logic        hwrite,                // write when high
    input  wire logic [2:0]  hsize,                 // transfer size
    input  wire logic [31:0] hwdata,                // write data
    input  wire logic        hready,                // bus ready in
    output logic             hreadyout,             // slave ready out
    output logic             hresp,                 // response, always okay
    output logic [31:0]      hrdata,                // read data

    input  wire logic        tx_start,              // request to send the pattern
    input  wire logic        tx_bit_req,            // modem wants the next bit
    output logic             tx_bit_q,              // current pattern bit
    output logic             tx_busy_q,             // pattern being sent

    input  wire logic        rx_bit,                // received data bit
    input  wire logic        rx_bit_valid,          // rx_bit is new this cycle
    output logic             pattern_found_q,       // one-cycle detect pulse

    output logic [3:0]       tx_filter_cutoff_code, // filter cutoff code k
    output logic [2:0]       tx_power_code,         // output power code
    output logic             clkout,                // buffered clock output
    output logic             clkout_en              // clock output pin enable
);
    // configuration registers
    logic [7:0]  rx_cfg_q;                          // receive pattern control
    logic [7:0]  pat_q [4];                         // pattern bytes, send order
    logic [7:0]  tx_cfg_q;                          // transmitter config
    logic [7:0]  osc_cfg_q;                         // clock output config

    // ahb data phase bookkeeping
    logic        wr_pend_q;                         // write data expected
    logic [5:0]  wr_idx_q;                          // index of pending write
    logic [31:0] hrdata_q;                          // registered read data

    // pattern sender
    stc_pkg::stc_tx_state_t tx_state_q;             // sender state
    logic [31:0] tx_shift_q;                        // bits still to send, msb first
    logic [5:0]  tx_left_q;                         // bits left to send

    // pattern detector
    logic [31:0] rx_shift_q;                        // last 32 received bits
    logic [5:0]  rx_fill_q;                         // bits seen, saturating

    // registered outputs
    logic        clkout_q;                          // gated divided clock
    logic        bypass_q;                          // divider zero, pass crystal
    logic        clkout_en_q;                       // pin enable

    // decode wires
    wire         addr_phase = hsel && hready && htrans[1];
    wire  [5:0]  addr_idx   = haddr[7:2];
    wire         word_ok    = (haddr[31:8] == '0) && (haddr[1:0] == 2'b00);
    wire  [1:0]  pat_size   = rx_cfg_q[stc_pkg::RX_SIZE_LSB +: 2];
    wire  [1:0]  pat_tol    = rx_cfg_q[stc_pkg::RX_TOL_LSB +: 2];
    wire         recog_en   = rx_cfg_q[stc_pkg::RX_RECOG_BIT];
    wire  [DIV_W-1:0] div_m = osc_cfg_q[stc_pkg::OSC_DIV_LSB +: DIV_W];
    wire         div_clk;                           // divided crystal clock
    wire  [31:0] pat_word   = {pat_q[0], pat_q[1], pat_q[2], pat_q[3]};
    wire  [5:0]  pat_bits   = {pat_size, 3'b000} + 6'd8;

    if (DIV_W < 1 || DIV_W > 6)
    begin : g_chk
        $error("stc_regs: DIV_W must fit bits 7..2 of the clock config");
    end

    // read value of a register index; unmapped indices read zero
    function automatic logic [7:0] reg_read(input logic [5:0] idx);
        case (idx)
            stc_pkg::IDX_RX_CFG:     reg_read = rx_cfg_q;
            stc_pkg::IDX_PAT_FIRST:  reg_read = pat_q[0];
            stc_pkg::IDX_PAT_SECOND: reg_read = pat_q[1];
            stc_pkg::IDX_PAT_THIRD:  reg_read = pat_q[2];
            stc_pkg::IDX_PAT_LAST:   reg_read = pat_q[3];
            stc_pkg::IDX_TX_CFG:     reg_read = tx_cfg_q;
            stc_pkg::IDX_OSC_CFG:    reg_read = osc_cfg_q;
            default:                 reg_read = 8'h00;
        endcase
    endfunction

    // count of ones in a 32-bit word
    function automatic logic [5:0] ones(input logic [31:0] v);
        logic [5:0] n;
        n = '0;
        for (int i = 0; i < 32; i++)
            n = n + {5'b00000, v[i]};
        ones = n;
    endfunction

    // pattern compare: the first byte is the oldest of the window
    wire  [4:0]  pat_shift  = 5'd24 - {pat_size, 3'b000};
    wire  [31:0] exp_word   = pat_word >> pat_shift;
    wire  [31:0] cmp_mask   = 32'hffff_ffff >> pat_shift;
    wire  [31:0] rx_next    = {rx_shift_q[30:0], rx_bit};
    wire  [5:0]  bit_errs   = ones((rx_next ^ exp_word) & cmp_mask);
    wire         enough     = (rx_fill_q + 6'd1) >= pat_bits;
    wire         match      = recog_en && rx_bit_valid && enough
                              && (bit_errs <= {4'b0000, pat_tol});

    // ahb data phase: capture write target, read data straight out
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= '0;
            hrdata_q  <= '0;
        end
        else if (ce && hready)
        begin
            // unaligned or out-of-range words behave as unmapped
            wr_pend_q <= addr_phase && hwrite && word_ok;
            wr_idx_q  <= addr_idx;
            // read value sampled at the address phase, so a read right
            // after a write to the same word sees the old value
            hrdata_q  <= (addr_phase && !hwrite && word_ok)
                         ? {24'h000000, reg_read(addr_idx)} : '0;
        end
    end

    // register writes during the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_cfg_q  <= stc_pkg::RST_RX_CFG;
            pat_q[0]  <= stc_pkg::RST_PAT;
            pat_q[1]  <= stc_pkg::RST_PAT;
            pat_q[2]  <= stc_pkg::RST_PAT;
            pat_q[3]  <= stc_pkg::RST_PAT;
            tx_cfg_q  <= stc_pkg::RST_TX_CFG;
            osc_cfg_q <= stc_pkg::RST_OSC_CFG;
        end
        else if (ce && wr_pend_q)
        begin
            case (wr_idx_q)
                stc_pkg::IDX_RX_CFG:     rx_cfg_q  <= hwdata[7:0] & stc_pkg::MASK_RX_CFG;
                stc_pkg::IDX_PAT_FIRST:  pat_q[0]  <= hwdata[7:0];
                stc_pkg::IDX_PAT_SECOND: pat_q[1]  <= hwdata[7:0];
                stc_pkg::IDX_PAT_THIRD:  pat_q[2]  <= hwdata[7:0];
                stc_pkg::IDX_PAT_LAST:   pat_q[3]  <= hwdata[7:0];
                stc_pkg::IDX_TX_CFG:     tx_cfg_q  <= hwdata[7:0] & stc_pkg::MASK_TX_CFG;
                stc_pkg::IDX_OSC_CFG:    osc_cfg_q <= hwdata[7:0] & stc_pkg::MASK_OSC_CFG;
                default:                 ;
            endcase
        end
    end

    // pattern sender: one bit per modem strobe
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_state_q <= stc_pkg::STC_IDLE;
            tx_shift_q <= '0;
            tx_left_q  <= '0;
            tx_bit_q   <= 1'b0;
            tx_busy_q  <= 1'b0;
        end
        else if (ce)
        begin
            case (tx_state_q)
                stc_pkg::STC_IDLE:
                begin
                    if (tx_start)
                    begin
                        tx_shift_q <= {pat_word[30:0], 1'b0};
                        tx_bit_q   <= pat_word[31];
                        tx_left_q  <= pat_bits;
                        tx_busy_q  <= 1'b1;
                        tx_state_q <= stc_pkg::STC_SEND;
                    end
                end
                stc_pkg::STC_SEND:
                begin
                    // the strobe consumes the bit on tx_bit_q
                    if (tx_bit_req)
                    begin
                        if (tx_left_q == 6'd1)
                        begin
                            tx_busy_q  <= 1'b0;
                            tx_bit_q   <= 1'b0;
                            tx_state_q <= stc_pkg::STC_IDLE;
                        end
                        else
                        begin
                            tx_bit_q   <= tx_shift_q[31];
                            tx_shift_q <= {tx_shift_q[30:0], 1'b0};
                        end
                        tx_left_q <= tx_left_q - 6'd1;
                    end
                end
                default:
                    tx_state_q <= stc_pkg::STC_IDLE;
            endcase
        end
    end

    // pattern detector: sliding window over the received stream
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_shift_q      <= '0;
            rx_fill_q       <= '0;
            pattern_found_q <= 1'b0;
        end
        else if (ce)
        begin
            pattern_found_q <= match;
            if (!recog_en)
                rx_fill_q <= '0;            // restart the window when off
            else if (rx_bit_valid)
            begin
                rx_shift_q <= rx_next;
                // a hit restarts the window so it is not reported twice
                if (match)
                    rx_fill_q <= '0;
                else if (rx_fill_q != 6'd32)
                    rx_fill_q <= rx_fill_q + 6'd1;
            end
        end
    end

    // clock output divider
    // crystal over two m
    stc_clk_div #(
        .DIV_W     (DIV_W)
    ) u_div (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .div_m     (div_m),
        .clk_div_q (div_clk)
    );

    // output flops: config fields and clock output control
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_filter_cutoff_code <= stc_pkg::RST_TX_CFG[stc_pkg::TX_CUTOFF_LSB +: 4];
            tx_power_code         <= stc_pkg::RST_TX_CFG[stc_pkg::TX_POWER_LSB +: 3];
            clkout_q              <= 1'b0;
            bypass_q              <= 1'b0;
            clkout_en_q           <= 1'b0;
        end
        else if (ce)
        begin
            tx_filter_cutoff_code <= tx_cfg_q[stc_pkg::TX_CUTOFF_LSB +: 4];

            tx_power_code         <= tx_cfg_q[stc_pkg::TX_POWER_LSB +: 3];

            clkout_en_q           <= osc_cfg_q[stc_pkg::OSC_EN_BIT];

            clkout_q              <= osc_cfg_q[stc_pkg::OSC_EN_BIT] & div_clk;

            bypass_q              <= osc_cfg_q[stc_pkg::OSC_EN_BIT] && (div_m == '0);
        end
    end

    // undivided crystal cannot come from a flop; bypass gates it instead
    assign clkout    = bypass_q ? hclk : clkout_q;
    assign clkout_en = clkout_en_q;
    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;                        // no wait states ever
    assign hresp     = stc_pkg::HRESP_OKAY;
endmodule

// ==== bench/stc_regs_props.sv ====
// stc_regs_props: port-level assertions for the configuration bank.
// assumes one hclk domain, hready tied to hreadyout, word accesses only.
`timescale 1ns/100ps
module stc_regs_props #(
    parameter int DIV_W = 5                        // divider field width
) (
    input wire logic        hclk,                  // crystal clock
    input wire logic        hresetn,               // async reset, active low
    input wire logic        ce,                    // clock enable
    input wire logic        hsel,                  // slave select
    input wire logic [31:0] haddr,                 // byte address
    input wire logic [1:0]  htrans,                // transfer type
    input wire logic        hwrite,                // write when high
    input wire logic [31:0] hwdata,                // write data
    input wire logic        hready,                // bus ready in
    input wire logic        hreadyout,             // slave ready out
    input wire logic        hresp,                 // response
    input wire logic [31:0] hrdata,                // read data
    input wire logic        tx_start,              // pattern send request
    input wire logic        tx_busy_q,             // pattern being sent
    input wire logic        rx_bit_valid,          // received bit strobe
    input wire logic        pattern_found_q,       // detect pulse
    input wire logic [3:0]  tx_filter_cutoff_code, // cutoff code
    input wire logic [2:0]  tx_power_code,         // power code
    input wire logic        clkout,                // buffered clock
    input wire logic        clkout_en              // clock pin enable
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [7:0] sh_q [0:9];                        // shadow of indices 0x12..0x1b
    logic       wr_q;                              // mapped write in data phase
    logic       rdhit_q;                           // mapped read in data phase
    logic       rd_q;                              // any read in data phase
    logic [5:0] idx_q;                             // data phase index
    logic       clk_prev_q;                        // clkout at the last edge
    logic [7:0] run_q;                             // edges since last clkout change
    logic [7:0] quiet_q;                           // edges since last divider write
    wire        take = hsel & hready & htrans[1] & ce;
    wire  [5:0] aidx = haddr[7:2];
    wire        hit  = haddr[31:8] == 24'h0 && haddr[1:0] == 2'b00 &&
                       (aidx == stc_pkg::IDX_RX_CFG ||
                        (aidx >= stc_pkg::IDX_PAT_FIRST && aidx <= stc_pkg::IDX_OSC_CFG));
    wire  [3:0] slot = 4'(idx_q - stc_pkg::IDX_RX_CFG);

    function automatic logic [7:0] rstv(input int i);
        return i == 0 ? stc_pkg::RST_RX_CFG : i == 8 ? stc_pkg::RST_TX_CFG :
               i == 9 ? stc_pkg::RST_OSC_CFG : stc_pkg::RST_PAT;
    endfunction
    function automatic logic [7:0] msk(input int i);
        return i == 0 ? stc_pkg::MASK_RX_CFG : i == 8 ? stc_pkg::MASK_TX_CFG :
               i == 9 ? stc_pkg::MASK_OSC_CFG : 8'hff;
    endfunction

    // shadow registers follow the bus; write lands at data phase end
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            for (int i = 0; i < 10; i++) sh_q[i] <= rstv(i);
            {wr_q, rdhit_q, rd_q, idx_q} <= '0;
        end
        else if (ce)
        begin
            if (wr_q) sh_q[slot] <= hwdata[7:0] & msk(int'(slot));
            wr_q    <= take & hwrite & hit;
            rdhit_q <= take & ~hwrite & hit;
            rd_q    <= take & ~hwrite;
            idx_q   <= aidx;
        end

    // divider watch; quiet gives a changed divider time to settle
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            {clk_prev_q, run_q, quiet_q} <= '0;
        end
        else if (ce)
        begin
            clk_prev_q <= clkout;
            run_q      <= (clkout != clk_prev_q) ? 8'h01 : run_q + 8'(run_q != 8'hff);
            quiet_q    <= (wr_q && slot == 4'h9) ? 8'h00 : quiet_q + 8'(quiet_q != 8'hff);
        end

    a_read_data: assert property (rd_q && ce |->
        hrdata == (rdhit_q ? {24'h0, sh_q[slot]} : 32'h0)) else $error("read data wrong");
    a_cutoff_copy: assert property ($past(hresetn) |->
        tx_filter_cutoff_code == $past(sh_q[8][7:4])) else $error("cutoff code wrong");
    a_power_copy: assert property ($past(hresetn) |->
        tx_power_code == $past(sh_q[8][3:1])) else $error("power code wrong");
    a_pin_enable: assert property ($past(hresetn) |->
        clkout_en == $past(sh_q[9][7])) else $error("clock pin enable wrong");
    a_clk_quiet: assert property (!clkout_en && !$past(clkout_en) |-> !clkout)
        else $error("clock on while off");
    a_div_period: assert property (clkout_en && clkout != clk_prev_q &&
        sh_q[9][6:2] != 5'h0 && quiet_q > 8'd80 |-> run_q == {3'h0, sh_q[9][6:2]})
        else $error("half period wrong");
    a_found_cause: assert property (pattern_found_q |->
        $past(rx_bit_valid) && $past(sh_q[0][5])) else $error("detect without cause");
    a_found_pulse: assert property (pattern_found_q |=> !pattern_found_q)
        else $error("detect pulse too long");
    a_busy_start: assert property ($rose(tx_busy_q) |-> $past(tx_start))
        else $error("send began unrequested");
    a_resp_okay: assert property (hreadyout && hresp == stc_pkg::HRESP_OKAY)
        else $error("bus answer not okay");

    c_send: cover property ($rose(tx_busy_q));
    c_found: cover property (pattern_found_q);
    c_toggle: cover property (clkout_en && clkout != clk_prev_q && quiet_q > 8'd80);
endmodule

// ==== bench/testbench.sv ====
// testbench: random and corner stimulus for stc_regs, self checking.
// assumes a no-wait-state slave; hsize and ce held constant.
`timescale 1ns/100ps
module testbench;
    logic        hclk, hresetn, ce, hsel, hwrite, tx_start, tx_bit_req, rx_bit, rx_bit_valid;
    logic [31:0] haddr, hwdata;                    // bus address and write data
    logic [1:0]  htrans;                           // transfer type
    logic [2:0]  hsize;                            // always word
    wire         hreadyout, hresp, tx_bit_q, tx_busy_q, pattern_found_q, clkout, clkout_en;
    wire  [31:0] hrdata;                           // read data
    wire  [3:0]  tx_filter_cutoff_code;            // cutoff code out
    wire  [2:0]  tx_power_code;                    // power code out
    wire         hready = hreadyout;               // single slave bus
    int          miscompares, n_checks;            // report counters
    logic [15:0] lfsr_q;                           // random source
    logic [31:0] pat, x;                           // pattern word, scratch
    logic [7:0]  d, seen;                          // scratch
    logic [5:0]  map  [0:6];                       // register indices
    logic [7:0]  rstv [0:6];                       // reset values
    logic [7:0]  mskv [0:6];                       // writable bits

    stc_regs #(.DIV_W(5)) uut (.*);

    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // one single transfer; entered just after a rising edge
    task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        hsel <= 1'b1; haddr <= {24'h0, i, 2'b00}; htrans <= stc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        htrans <= 2'b00; hsel <= 1'b0; hwdata <= {24'h0, wd};
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100)
        begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic wreg(input logic [5:0] i, input logic [7:0] v);
        logic [31:0] r;
        bus(i, 1'b1, v, r);
    endtask
    task automatic rchk(input logic [5:0] i, input logic [7:0] e);
        logic [31:0] r;
        bus(i, 1'b0, 8'h00, r);
        chk("read data", {24'h0, e}, r);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial
    begin
        repeat (100000) @(posedge hclk);
        miscompares++;
        stop_test();
    end

    initial
    begin
        {hresetn, hsel, hwrite, tx_start, tx_bit_req, rx_bit, rx_bit_valid} = '0;
        {haddr, hwdata, htrans} = '0;
        ce = 1'b1; hsize = stc_pkg::HSIZE_WORD; lfsr_q = 16'd60331;
        map  = '{stc_pkg::IDX_RX_CFG, stc_pkg::IDX_PAT_FIRST, stc_pkg::IDX_PAT_SECOND,
                 stc_pkg::IDX_PAT_THIRD, stc_pkg::IDX_PAT_LAST, stc_pkg::IDX_TX_CFG,
                 stc_pkg::IDX_OSC_CFG};
        rstv = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h70, 8'hbc};
        mskv = '{8'h3e, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfe, 8'hfc};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int k = 0; k < 7; k++) rchk(map[k], rstv[k]);
        wreg(6'h13, 8'hff);
        rchk(6'h13, 8'h00);
        for (int k = 0; k < 7; k++) begin wreg(map[k], 8'hff); rchk(map[k], mskv[k]); end
        for (int j = 0; j < 16; j++)
        begin
            x = 32'(rnd() % 7); d = 8'(rnd());
            wreg(map[x], d);
            rchk(map[x], d & mskv[x]);
        end
        for (int c = 0; c < 16; c++)
        begin
            wreg(stc_pkg::IDX_TX_CFG, {c[3:0], c[2:0], 1'b1});
            repeat (2) @(posedge hclk);
            chk("cutoff", 32'(c), 32'(tx_filter_cutoff_code));
            chk("power", 32'(c[2:0]), 32'(tx_power_code));
        end
        for (int s = 0; s < 4; s++)
        begin
            pat = {rnd(), rnd()};
            for (int b = 0; b < 4; b++) wreg(map[b + 1], pat[31 - 8 * b -: 8]);
            wreg(stc_pkg::IDX_RX_CFG, {3'b000, s[1:0], 3'b000});
            tx_start <= 1'b1;
            @(posedge hclk);
            tx_start <= 1'b0;
            for (int n = 0; n < 8 && tx_busy_q !== 1'b1; n++) @(posedge hclk);
            for (int i = 0; i < 8 * (s + 1); i++)
            begin
                chk("busy and bit", {31'h1, pat[31 - i]}, {tx_busy_q, tx_bit_q});
                tx_bit_req <= 1'b1;
                @(posedge hclk);
                tx_bit_req <= 1'b0;
                @(posedge hclk);
            end
            @(posedge hclk);
            chk("busy end", 32'h0, 32'(tx_busy_q));
        end
        // last detect trial has recognition off
        for (int t = 0; t <= 16; t++)
        begin
            wreg(stc_pkg::IDX_RX_CFG, {5'h0, t[3:2], 1'b0});
            wreg(stc_pkg::IDX_RX_CFG, {2'b00, t < 16, 2'b00, t[3:2], 1'b0});
            d = pat[31:24] ^ ((8'h01 << t[1:0]) - 8'h01);
            seen = 8'h00;
            for (int i = 0; i < 11; i++)
            begin
                rx_bit <= d[7 - i % 8]; rx_bit_valid <= i < 8;
                @(posedge hclk);
                rx_bit_valid <= 1'b0;
                @(posedge hclk);
                seen = seen | 8'(pattern_found_q);
            end
            chk("found", 32'(t < 16 && t[1:0] <= t[3:2]), 32'(seen));
        end
        // clock out: bypass, divided, off; a divided level holds over half a cycle
        foreach (mskv[k])
        begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : (k == 2) ? 8'h1f : 8'(rnd() % 31 + 1);
            wreg(stc_pkg::IDX_OSC_CFG, {(k != 6), d[4:0], 2'b11});
            repeat (150) @(posedge hclk);
            chk("pin enable", 32'(k != 6), 32'(clkout_en));
            #5;
            seen = {7'h0, clkout};
            chk("clk high", 32'(k == 0 || (k < 6 && seen[0])), 32'(clkout));
            @(negedge hclk);
            #5;
            chk("clk low", 32'(k > 0 && k < 6 && seen[0]), 32'(clkout));
            @(posedge hclk);
        end
        stop_test();
    end
endmodule

bind stc_regs stc_regs_props #(.DIV_W(DIV_W)) u_props (.*);
